//--- hdl/tdr_fifo.sv
`timescale 1ns/1ps
`default_nettype none

module tdr_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Write and read ports
  tdr_fifo_if.mem io
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] ram [DEPTH];
  logic [AW:0] wptr;
  logic [AW:0] rptr;
  logic [AW:0] next_wptr;
  logic [AW:0] next_rptr;
  logic [WIDTH-1:0] rdata;
  logic [WIDTH-1:0] next_rdata;
  logic rvalid;
  logic next_rvalid;
  logic do_wr;
  logic do_rd;

  // ==========================================================
  // Flags and pointers
  // Writes into a full buffer and reads of an empty one are dropped
  assign io.full = (wptr[AW] != rptr[AW]) && (wptr[AW-1:0] == rptr[AW-1:0]);
  assign io.empty = (wptr == rptr);
  assign do_wr = io.wr_en && !io.full && !io.clear;
  assign do_rd = io.rd_en && !io.empty && !io.clear;
  assign io.rd_data = rdata;
  assign io.rd_valid = rvalid;

  always_comb begin
    next_wptr = wptr + (AW+1)'(do_wr);
    next_rptr = rptr + (AW+1)'(do_rd);
    next_rvalid = do_rd;
    next_rdata = do_rd ? ram[rptr[AW-1:0]] : rdata;
    if (io.clear) begin
      next_wptr = '0;
      next_rptr = '0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wptr <= '0;
      rptr <= '0;
      rvalid <= 1'b0;
      rdata <= '0;
    end else begin
      wptr <= next_wptr;
      rptr <= next_rptr;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
    end
  end

  // ==========================================================
  // Storage, no reset so it maps onto plain RAM
  always_ff @(posedge sys_clk) begin
    if (do_wr) begin
      ram[wptr[AW-1:0]] <= io.wr_data;
    end
  end

endmodule

`default_nettype wire

//--- hdl/tdr_fifo_if.sv
`timescale 1ns/1ps
`default_nettype none

interface tdr_fifo_if #(parameter int WIDTH = 10) ();
  logic clear;
  logic wr_en;
  logic [WIDTH-1:0] wr_data;
  logic full;
  logic rd_en;
  logic [WIDTH-1:0] rd_data;
  logic rd_valid;
  logic empty;
  modport user (output clear, wr_en, wr_data, rd_en, input full, rd_data, rd_valid, empty);
  modport mem (input clear, wr_en, wr_data, rd_en, output full, rd_data, rd_valid, empty);
endinterface

`default_nettype wire

//--- hdl/tdr_pkg.sv
package tdr_pkg;

  typedef enum logic [2:0] {
    RST_MONITOR = 3'b001,
    RST_WAIT_CLK = 3'b010,
    RST_PULSE = 3'b100
  } tdr_rst_state_type;

  typedef enum logic [2:0] {
    PER_CTRL = 3'b001,
    PER_VIDEO = 3'b010,
    PER_ISLAND = 3'b100
  } tdr_period_type;

endpackage

//--- hdl/tdr_regs.svh
`ifndef TDR_REGS_SVH
`define TDR_REGS_SVH

// ==========================================================
// Timing
`define TDR_SYS_PERIOD_NS 8
`define TDR_LINK_PERIOD_NS 160
`define TDR_HOLD_LINK_CYCLES 3
`define TDR_SETTLE_CYCLES 1024
`define TDR_X5_DIV 4
`define TDR_SEQ_LAST 3'h4

// ==========================================================
// Sizes and thresholds
`define TDR_CDC_DEPTH 4
`define TDR_DESKEW_DEPTH 16
`define TDR_RUN_DVI 8'h80
`define TDR_RUN_HDMI 8'h0c
`define TDR_RUN_MAX 8'hff

// ==========================================================
// Multiplier status bit positions
`define TDR_ST_LINK_CLOCK_IN 1
`define TDR_ST_FX 2

// ==========================================================
// Symbol codes, control bits {c1,c0} in the name
`define TDR_TOK_00 10'h354
`define TDR_TOK_01 10'h0ab
`define TDR_TOK_10 10'h154
`define TDR_TOK_11 10'h2ab
`define TDR_PRE_VIDEO 4'h1
`define TDR_PRE_ISLAND 4'h5
// Nibble n sits at bits [10*n +: 10]
`define TDR_TERC4 {10'h2c3, 10'h163, 10'h271, 10'h28e, 10'h2c6, 10'h19c, 10'h139, 10'h2cc, \
  10'h13c, 10'h18e, 10'h11e, 10'h171, 10'h2e2, 10'h2e4, 10'h263, 10'h29c}

`endif

//--- hdl/tdr_rst.sv
`timescale 1ns/1ps
`default_nettype none
`include "tdr_regs.svh"

module tdr_rst #(
  parameter int SETTLE_CYCLES = `TDR_SETTLE_CYCLES,
  parameter int LINK_PERIOD_NS = `TDR_LINK_PERIOD_NS
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Multiplier indicators, asynchronous
  input wire logic synth_locked,
  input wire logic link_clock_in_toggle,
  input wire logic fx_toggle,
  // Multiplier reset
  output logic synth_reset
);
  localparam int HOLD_NS = `TDR_HOLD_LINK_CYCLES * LINK_PERIOD_NS;
  localparam int HOLD_CYC = (HOLD_NS + `TDR_SYS_PERIOD_NS - 1) / `TDR_SYS_PERIOD_NS;

  logic [2:0] ind_s1;
  logic [2:0] ind_s2;
  tdr_pkg::tdr_rst_state_type state;
  tdr_pkg::tdr_rst_state_type next_state;
  logic [15:0] count;
  logic [15:0] next_count;
  logic next_reset;
  logic fault;

  // ==========================================================
  // Indicator synchronisers: {fx, link_clock_in, locked}
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ind_s1 <= '0;
      ind_s2 <= '0;
    end else begin
      ind_s1 <= {fx_toggle, link_clock_in_toggle, synth_locked};
      ind_s2 <= ind_s1;
    end
  end

  // ==========================================================
  // Supervisor; the settle time also covers relock after a pulse
  assign fault = !ind_s2[0] || !ind_s2[1] || !ind_s2[2];

  always_comb begin
    next_state = state;
    next_count = count + 16'h0001;
    unique case (state)
      tdr_pkg::RST_MONITOR: begin
        if (!fault) begin
          next_count = '0;
        end else if (count == 16'(SETTLE_CYCLES - 1)) begin
          next_state = tdr_pkg::RST_WAIT_CLK;
          next_count = '0;
        end
      end
      tdr_pkg::RST_WAIT_CLK: begin
        next_count = '0;
        if (ind_s2[1]) begin
          next_state = tdr_pkg::RST_PULSE;
        end
      end
      tdr_pkg::RST_PULSE: begin
        if (count == 16'(HOLD_CYC - 1)) begin
          next_state = tdr_pkg::RST_MONITOR;
          next_count = '0;
        end
      end
    endcase
    next_reset = (next_state == tdr_pkg::RST_PULSE);
  end

  // Runs on the steady system clock, never on the link clock
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= tdr_pkg::RST_MONITOR;
      count <= '0;
      synth_reset <= 1'b0;
    end else begin
      state <= next_state;
      count <= next_count;
      synth_reset <= next_reset;
    end
  end

endmodule

`default_nettype wire

//--- hdl/tdr_rx.sv
`timescale 1ns/1ps
`default_nettype none
`include "tdr_regs.svh"

module tdr_rx #(
  parameter int X5_DIV = `TDR_X5_DIV,
  parameter int DESKEW_DEPTH = `TDR_DESKEW_DEPTH,
  parameter int SETTLE_CYCLES = `TDR_SETTLE_CYCLES,
  parameter int LINK_PERIOD_NS = `TDR_LINK_PERIOD_NS
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Link pins, channel 0 blue, 1 green, 2 red
  input wire logic link_clock_in,
  input wire logic [2:0] rise_bit,
  input wire logic [2:0] fall_bit,
  // Clock multiplier
  input wire logic synth_locked,
  input wire logic [2:0] synth_status,
  output logic synth_reset,
  // Configuration and status
  input wire logic hdmi_mode,
  output logic [2:0] word_lock,
  output logic [2:0] deskew_ready,
  // Decoded stream
  output logic [2:0][7:0] pixel_data,
  output logic [2:0][3:0] aux_data,
  output logic [2:0][1:0] ctrl_data,
  output logic video_active,
  output logic island_active,
  output logic video_preamble,
  output logic island_preamble,
  output logic hsync,
  output logic vsync
);

  // ==========================================================
  // Symbol helpers
  function automatic logic is_ctrl(input logic [9:0] w);
    return (w == `TDR_TOK_00) || (w == `TDR_TOK_01) || (w == `TDR_TOK_10) || (w == `TDR_TOK_11);
  endfunction

  function automatic logic [1:0] ctrl_bits(input logic [9:0] w);
    return (w == `TDR_TOK_01) ? 2'h1 : (w == `TDR_TOK_10) ? 2'h2 : (w == `TDR_TOK_11) ? 2'h3 : 2'h0;
  endfunction

  function automatic logic [7:0] tmds_dec(input logic [9:0] w);
    logic [7:0] d;
    logic [7:0] q;
    d = w[9] ? ~w[7:0] : w[7:0];
    q[0] = d[0];
    for (int i = 1; i < 8; i++) begin
      q[i] = w[8] ? (d[i] ^ d[i-1]) : ~(d[i] ^ d[i-1]);
    end
    return q;
  endfunction

  function automatic logic [3:0] terc4_dec(input logic [9:0] w);
    logic [159:0] tab;
    logic [3:0] n;
    tab = `TDR_TERC4;
    n = 4'h0;
    for (int i = 0; i < 16; i++) begin
      if (w == tab[i*10 +: 10]) begin
        n = 4'(i);
      end
    end
    return n;
  endfunction

  // ==========================================================
  // Pin synchronisers
  logic [2:0] link_sync;
  logic [2:0] rise_s1;
  logic [2:0] rise_s2;
  logic [2:0] fall_s1;
  logic [2:0] fall_s2;
  logic pix_tick;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      link_sync <= '0;
      rise_s1 <= '0;
      rise_s2 <= '0;
      fall_s1 <= '0;
      fall_s2 <= '0;
    end else begin
      link_sync <= {link_sync[1:0], link_clock_in};
      rise_s1 <= rise_bit;
      rise_s2 <= rise_s1;
      fall_s1 <= fall_bit;
      fall_s2 <= fall_s1;
    end
  end

  assign pix_tick = link_sync[1] && !link_sync[2];

  // ==========================================================
  // x5 enable, restarted on each link rising edge
  logic [7:0] x5_cnt;
  logic [7:0] next_x5_cnt;
  logic x5_tick;

  assign x5_tick = (x5_cnt == 8'(X5_DIV - 1));

  always_comb begin
    next_x5_cnt = x5_cnt + 8'h01;
    if (pix_tick || x5_tick) begin
      next_x5_cnt = '0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      x5_cnt <= '0;
    end else begin
      x5_cnt <= next_x5_cnt;
    end
  end

  // ==========================================================
  // Multiplier supervisor
  tdr_rst #(.SETTLE_CYCLES(SETTLE_CYCLES), .LINK_PERIOD_NS(LINK_PERIOD_NS)) u_rst (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .synth_locked(synth_locked),
    .link_clock_in_toggle(synth_status[`TDR_ST_LINK_CLOCK_IN]),
    .fx_toggle(synth_status[`TDR_ST_FX]),
    .synth_reset(synth_reset)
  );

  // ==========================================================
  // Per channel recovery and deskew
  logic all_valid;
  logic all_ready;
  logic [2:0] ds_valid;
  logic [2:0][9:0] ds_word;

  assign all_valid = &word_lock;
  assign all_ready = &deskew_ready;

  for (genvar g = 0; g < 3; g++) begin : g_ch
    tdr_fifo_if #(.WIDTH(10)) cdc_io ();
    tdr_fifo_if #(.WIDTH(10)) ds_io ();
    logic [9:0] shreg;
    logic [9:0] next_shreg;
    logic [2:0] seq;
    logic [2:0] next_seq;
    logic [9:0] raw_prev;
    logic [9:0] next_raw_prev;
    logic [9:0] word;
    logic [9:0] next_word;
    logic [3:0] offset;
    logic [3:0] next_offset;
    logic [3:0] hit_off;
    logic [7:0] run;
    logic [7:0] next_run;
    logic lock;
    logic next_lock;
    logic word_stb;
    logic next_word_stb;
    logic hit;
    logic ready;
    logic next_ready;
    logic tok_seen;
    logic next_tok_seen;
    logic [19:0] pair;

    tdr_fifo #(.WIDTH(10), .DEPTH(`TDR_CDC_DEPTH)) u_cdc (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .io(cdc_io)
    );

    // Depth well above the 0.6 pixel skew the link may carry
    tdr_fifo #(.WIDTH(10), .DEPTH(DESKEW_DEPTH)) u_deskew (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .io(ds_io)
    );

    // Deserializer, first bit lands at bit 0
    always_comb begin
      next_shreg = shreg;
      next_seq = seq;
      if (x5_tick) begin
        next_shreg = {fall_s2[g], rise_s2[g], shreg[9:2]};
        next_seq = (seq == `TDR_SEQ_LAST) ? 3'h0 : seq + 3'h1;
      end
    end

    assign cdc_io.clear = synth_reset;
    assign cdc_io.wr_en = x5_tick && (seq == `TDR_SEQ_LAST);
    assign cdc_io.wr_data = next_shreg;
    assign cdc_io.rd_en = pix_tick;

    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        shreg <= '0;
        seq <= '0;
      end else begin
        shreg <= next_shreg;
        seq <= next_seq;
      end
    end

    // Word aligner and lock detection
    assign pair = {cdc_io.rd_data, raw_prev};

    always_comb begin
      hit = 1'b0;
      hit_off = offset;
      for (int k = 9; k >= 0; k--) begin
        if (is_ctrl(pair[k +: 10])) begin
          hit = 1'b1;
          hit_off = 4'(k);
        end
      end
      next_raw_prev = raw_prev;
      next_offset = offset;
      next_word = word;
      next_run = run;
      next_lock = lock;
      next_word_stb = 1'b0;
      if (synth_reset) begin
        next_offset = '0;
        next_run = '0;
        next_lock = 1'b0;
      end else if (cdc_io.rd_valid) begin
        next_raw_prev = cdc_io.rd_data;
        if (!lock && hit) begin
          next_offset = hit_off;
        end
        next_word = pair[next_offset +: 10];
        next_word_stb = 1'b1;
        if (!is_ctrl(next_word)) begin
          next_run = '0;
        end else if (run != `TDR_RUN_MAX) begin
          next_run = run + 8'h01;
        end
        if ((next_run == `TDR_RUN_HDMI) || (next_run == `TDR_RUN_DVI)) begin
          next_lock = 1'b1;
        end
      end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        raw_prev <= '0;
        offset <= '0;
        word <= '0;
        run <= '0;
        lock <= 1'b0;
        word_stb <= 1'b0;
      end else begin
        raw_prev <= next_raw_prev;
        offset <= next_offset;
        word <= next_word;
        run <= next_run;
        lock <= next_lock;
        word_stb <= next_word_stb;
      end
    end

    assign word_lock[g] = lock;

    // Deskew handshake, only the first token of a run is a marker
    assign ds_io.clear = synth_reset || !all_valid;
    assign ds_io.wr_en = all_valid && word_stb;
    assign ds_io.wr_data = word;
    assign ds_io.rd_en = all_valid && pix_tick && !ready;

    always_comb begin
      next_ready = ready;
      next_tok_seen = tok_seen;
      if (synth_reset || !all_valid) begin
        next_ready = 1'b0;
        next_tok_seen = 1'b0;
      end else if (all_ready) begin
        next_ready = 1'b0;
      end else if (ds_io.rd_valid) begin
        next_tok_seen = is_ctrl(ds_io.rd_data);
        if (is_ctrl(ds_io.rd_data) && !tok_seen) begin
          next_ready = 1'b1;
        end
      end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        ready <= 1'b0;
        tok_seen <= 1'b0;
      end else begin
        ready <= next_ready;
        tok_seen <= next_tok_seen;
      end
    end

    assign deskew_ready[g] = ready;
    assign ds_valid[g] = ds_io.rd_valid;
    assign ds_word[g] = ds_io.rd_data;
  end

  // ==========================================================
  // Decoder; a held marker is decoded once on release
  tdr_pkg::tdr_period_type period;
  tdr_pkg::tdr_period_type next_period;
  logic dec_stb;
  logic [3:0] ctl_nib;
  logic [2:0][7:0] next_pixel;
  logic [2:0][3:0] next_aux;
  logic [2:0][1:0] next_ctrl;
  logic next_video;
  logic next_island;
  logic next_vpre;
  logic next_ipre;

  assign dec_stb = (&ds_valid) || all_ready;
  assign ctl_nib = {ctrl_bits(ds_word[2]), ctrl_bits(ds_word[1])};

  always_comb begin
    next_period = period;
    next_pixel = pixel_data;
    next_aux = aux_data;
    next_ctrl = ctrl_data;
    next_video = video_active;
    next_island = island_active;
    next_vpre = video_preamble;
    next_ipre = island_preamble;
    if (synth_reset) begin
      next_period = tdr_pkg::PER_CTRL;
      next_video = 1'b0;
      next_island = 1'b0;
    end else if (dec_stb) begin
      next_vpre = 1'b0;
      next_ipre = 1'b0;
      if (is_ctrl(ds_word[0])) begin
        next_video = 1'b0;
        next_island = 1'b0;
        for (int c = 0; c < 3; c++) begin
          next_ctrl[c] = ctrl_bits(ds_word[c]);
        end
        next_period = tdr_pkg::PER_CTRL;
        if (hdmi_mode) begin
          next_vpre = (ctl_nib == `TDR_PRE_VIDEO);
          next_ipre = (ctl_nib == `TDR_PRE_ISLAND);
          if (next_vpre) begin
            next_period = tdr_pkg::PER_VIDEO;
          end else if (next_ipre) begin
            next_period = tdr_pkg::PER_ISLAND;
          end
        end
      end else if (!hdmi_mode) begin
        next_video = 1'b1;
        next_island = 1'b0;
        for (int c = 0; c < 3; c++) begin
          next_pixel[c] = tmds_dec(ds_word[c]);
        end
      end else begin
        unique case (period)
          tdr_pkg::PER_VIDEO: begin
            next_video = 1'b1;
            next_island = 1'b0;
            for (int c = 0; c < 3; c++) begin
              next_pixel[c] = tmds_dec(ds_word[c]);
            end
          end
          tdr_pkg::PER_ISLAND: begin
            next_island = 1'b1;
            next_video = 1'b0;
            for (int c = 0; c < 3; c++) begin
              next_aux[c] = terc4_dec(ds_word[c]);
            end
          end
          tdr_pkg::PER_CTRL: begin
            next_video = 1'b0;
            next_island = 1'b0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      period <= tdr_pkg::PER_CTRL;
      pixel_data <= '0;
      aux_data <= '0;
      ctrl_data <= '0;
      video_active <= 1'b0;
      island_active <= 1'b0;
      video_preamble <= 1'b0;
      island_preamble <= 1'b0;
    end else begin
      period <= next_period;
      pixel_data <= next_pixel;
      aux_data <= next_aux;
      ctrl_data <= next_ctrl;
      video_active <= next_video;
      island_active <= next_island;
      video_preamble <= next_vpre;
      island_preamble <= next_ipre;
    end
  end

  assign hsync = ctrl_data[0][0];
  assign vsync = ctrl_data[0][1];

endmodule

`default_nettype wire

//--- verif/tdr_rx_asserts.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================
// Port checker
module tdr_rx_asserts #(
  parameter int LINK_PERIOD_NS = 160
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Multiplier side
  input wire logic [2:0] synth_status,
  input wire logic synth_reset,
  // Mode and status
  input wire logic hdmi_mode,
  input wire logic [2:0] word_lock,
  // Decoded stream
  input wire logic [2:0][1:0] ctrl_data,
  input wire logic video_active,
  input wire logic island_active,
  input wire logic video_preamble,
  input wire logic island_preamble,
  input wire logic hsync,
  input wire logic vsync
);
  // Three link periods in 8 ns steps, rounded up
  localparam int HOLD = (3 * LINK_PERIOD_NS + 7) / 8;
  logic [7:0] hi_cnt;
  logic [7:0] next_hi_cnt;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  always_comb begin
    next_hi_cnt = synth_reset ? hi_cnt + 8'h01 : 8'h00;
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hi_cnt <= 8'h00;
    end else begin
      hi_cnt <= next_hi_cnt;
    end
  end

  sequence s_pulse_end;
    $fell(synth_reset);
  endsequence
  sequence s_pulse_on;
    synth_reset [*2];
  endsequence

  a_pulse_width: assert property (s_pulse_end |-> hi_cnt == 8'(HOLD))
    else $error("multiplier reset width wrong");
  a_reset_needs_clk: assert property ($rose(synth_reset) |-> $past(synth_status[1], 2))
    else $error("multiplier reset without input clock");
  a_lock_cleared: assert property (s_pulse_on |-> word_lock == 3'h0)
    else $error("lock kept during multiplier reset");
  a_lock_held: assert property (|($past(word_lock) & ~word_lock) |-> $past(synth_reset))
    else $error("lock dropped without multiplier reset");
  a_dvi_no_island: assert property (!hdmi_mode |-> !island_active)
    else $error("island active in dvi mode");
  a_dvi_no_pre: assert property (!hdmi_mode |-> !(video_preamble || island_preamble))
    else $error("preamble flag in dvi mode");
  // Control bits and sync only move on a token, which blanks both periods
  a_sync_map: assert property ($changed({ctrl_data, hsync, vsync}) |-> !video_active && !island_active)
    else $error("sync or control bits moved outside blanking");
  a_actives_excl: assert property (!(video_active && island_active))
    else $error("video and island active together");
endmodule

bind tdr_rx tdr_rx_asserts #(.LINK_PERIOD_NS(LINK_PERIOD_NS)) u_asserts (
  .sys_clk, .rst_n, .synth_status, .synth_reset, .hdmi_mode, .word_lock, .ctrl_data,
  .video_active, .island_active, .video_preamble, .island_preamble, .hsync, .vsync);

`default_nettype wire

//--- verif/tdr_rx_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "tdr_regs.svh"

module tdr_rx_tb_top;
  localparam int SETTLE = 16;
  localparam logic [159:0] T4 = `TDR_TERC4;
  logic sys_clk, rst_n, synth_locked, hdmi_mode, run, link_clock_in, synth_reset, found;
  logic video_active, island_active, video_preamble, island_preamble, hsync, vsync;
  logic [2:0] rise_bit, fall_bit, synth_status, word_lock, deskew_ready;
  logic [2:0][9:0] sym;
  logic [2:0][7:0] pixel_data;
  logic [2:0][3:0] aux_data;
  logic [2:0][1:0] ctrl_data;
  int error_cnt, compares, n;

  tdr_src u_src (.run, .sym, .link_clock_in, .rise_bit, .fall_bit);
  tdr_rx #(.SETTLE_CYCLES(SETTLE)) u_dut (.sys_clk, .rst_n, .link_clock_in, .rise_bit,
    .fall_bit, .synth_locked, .synth_status, .synth_reset, .hdmi_mode, .word_lock,
    .deskew_ready, .pixel_data, .aux_data, .ctrl_data, .video_active, .island_active,
    .video_preamble, .island_preamble, .hsync, .vsync);

  // ==========================================
  // Helpers
  task check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task give_verdict;
    $display("compares %0d, mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task do_reset(input logic hd);
    @(posedge sys_clk);
    #1 rst_n = 1'b0;
    hdmi_mode = hd;
    repeat (3) @(posedge sys_clk);
    #1 rst_n = 1'b1;
  endtask

  task send(input logic [9:0] b, input logic [9:0] g, input logic [9:0] r, input int cnt);
    repeat (cnt) begin
      @(negedge link_clock_in);
      sym = {r, g, b};
    end
  endtask

  function automatic logic [7:0] dec8(input logic [9:0] s);
    logic [7:0] q;
    q = s[9] ? ~s[7:0] : s[7:0];
    dec8[0] = q[0];
    for (int i = 1; i < 8; i++) begin
      dec8[i] = s[8] ? q[i] ^ q[i - 1] : ~(q[i] ^ q[i - 1]);
    end
  endfunction

  // Same word on all channels; late checks allow for the pipeline delay
  task burst(input logic chk, input logic isl);
    logic [9:0] s;
    for (int k = 0; k < 14; k++) begin
      s = isl ? T4[10 * k +: 10] : {2'b01, 8'(k * 37 + 5)};
      send(s, s, s, 1);
      if (chk && k >= 9) begin
        found = 1'b0;
        for (int j = 0; j <= k; j++) begin
          if (isl ? aux_data[0] === 4'(j) : pixel_data[0] === dec8({2'b01, 8'(j * 37 + 5)}))
            found = 1'b1;
        end
        check(found, 1'b1);
        check({video_active, island_active}, {!isl, isl});
        check({pixel_data[1], pixel_data[2]}, {2{pixel_data[0]}});
        check({aux_data[1], aux_data[2]}, {2{aux_data[0]}});
      end
    end
  endtask

  // ==========================================
  // Clock, watchdog and tests
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  initial begin
    #200000;
    error_cnt++;
    give_verdict;
  end

  initial begin
    rst_n = 1'b0;
    synth_locked = 1'b1;
    synth_status = 3'b110;
    hdmi_mode = 1'b0;
    run = 1'b0;
    sym = {3{`TDR_TOK_00}};
    error_cnt = 0;
    compares = 0;
    do_reset(1'b0);
    check({word_lock, synth_reset, video_active, island_active}, 6'h00);
    run = 1'b1;
    send(`TDR_TOK_10, `TDR_TOK_00, `TDR_TOK_00, 24);
    check(word_lock, 3'h7);
    check({video_active, hsync, vsync}, 3'b001);
    burst(1'b0, 1'b0);
    send(`TDR_TOK_10, `TDR_TOK_00, `TDR_TOK_00, 16);
    check(deskew_ready, 3'h0);
    burst(1'b1, 1'b0);
    $display("dvi test done");
    do_reset(1'b1);
    send(`TDR_TOK_11, `TDR_TOK_01, `TDR_TOK_00, 24);
    check({word_lock, video_active, island_active}, 5'h1c);
    check({video_preamble, island_preamble}, 2'b10);
    check({ctrl_data[2], ctrl_data[1], hsync, vsync}, 6'h07);
    burst(1'b0, 1'b0);
    send(`TDR_TOK_11, `TDR_TOK_01, `TDR_TOK_00, 16);
    burst(1'b1, 1'b0);
    send(`TDR_TOK_11, `TDR_TOK_01, `TDR_TOK_01, 16);
    check({video_preamble, island_preamble, ctrl_data[2]}, 4'h5);
    burst(1'b1, 1'b1);
    send(`TDR_TOK_00, `TDR_TOK_00, `TDR_TOK_00, 16);
    send(10'h105, 10'h105, 10'h105, 10);
    check({video_active, island_active, video_preamble, island_preamble}, 4'h0);
    $display("hdmi test done");
    run = 1'b0;
    @(posedge sys_clk);
    #1 synth_locked = 1'b0;
    synth_status = 3'b000;
    repeat (SETTLE + 30) @(posedge sys_clk);
    #1 check(synth_reset, 1'b0);
    synth_status = 3'h2;
    n = 0;
    while (synth_reset !== 1'b1 && n < 40) begin
      @(posedge sys_clk);
      #1 n++;
    end
    n = 0;
    do begin
      n++;
      @(posedge sys_clk);
      #1;
    end while (synth_reset === 1'b1 && n < 200);
    check(16'(n), 16'h003c);
    check(word_lock, 3'h0);
    synth_locked = 1'b1;
    synth_status = 3'b110;
    run = 1'b1;
    send(`TDR_TOK_10, `TDR_TOK_00, `TDR_TOK_00, 24);
    check(word_lock, 3'h7);
    $display("supervisor test done");
    give_verdict;
  end
endmodule

`default_nettype wire

//--- verif/tdr_src.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================
// Video source model
module tdr_src (
  // From the bench
  input wire logic run,
  input wire logic [2:0][9:0] sym,
  // Link pins
  output logic link_clock_in,
  output logic [2:0] rise_bit,
  output logic [2:0] fall_bit
);
  logic [2:0][9:0] cur;
  logic [9:0] red_late;

  initial begin
    link_clock_in = 1'b0;
    rise_bit = 3'h0;
    fall_bit = 3'h0;
    red_late = 10'h354;
    // Start only once the bench has set its inputs, so no unknown reaches the pins
    wait (run === 1'b0 && ^sym !== 1'bx);
    forever begin
      // Red runs one pixel late so there is real skew to remove
      cur = {red_late, sym[1], sym[0]};
      red_late = sym[2];
      for (int j = 0; j < 10; j++) begin
        link_clock_in = run && j < 5;
        // Bit 0 goes first; an unplugged cable shows a toggling pattern
        for (int c = 0; c < 3; c++) begin
          rise_bit[c] = run ? cur[c][j / 2 * 2] : ~rise_bit[c];
          fall_bit[c] = run ? cur[c][j / 2 * 2 + 1] : ~fall_bit[c];
        end
        #16;
      end
    end
  end
endmodule

`default_nettype wire
